// ==== core/uam_alarm_manager.sv ====
// user alarm manager: active list, responses, clearing and registers
// assumes a cycle tick at the end of each user program pass and
// a power cycle seen as sys_rst_i
`timescale 1ns/1ps

module uam_alarm_manager
    import uam_pkg::*;
#(
    parameter int NUM_ALARMS = UAM_NUM_ALARMS,  // user alarms
    parameter int DISP_SLOTS = UAM_DISP_SLOTS   // presented slots
) (
    input  wire logic        clk_i,                   // 100 MHz
    input  wire logic        sys_rst_i,               // power cycle
    input  wire logic [11:0] addr_i,                  // byte address
    input  wire logic [31:0] wdata_i,                 // write data
    input  wire logic        wr_i,                    // write strobe
    input  wire logic        rd_i,                    // read strobe
    output logic      [31:0] rdata_o,                 // read data
    input  wire logic        cycle_tick_i,            // program pass done
    input  wire logic        key_clear_i,             // cancel or reset key
    input  wire logic        iface_start_inhibit_i,   // program's own signals
    input  wire logic        iface_readin_inhibit_i,
    input  wire logic        iface_feed_inhibit_i,
    input  wire logic        iface_emergency_halt_i,
    output logic             kern_start_inhibit_o,    // to numerical_control_kernel
    output logic             kern_readin_inhibit_o,
    output logic             kern_feed_inhibit_o,
    output logic             kern_emergency_halt_o,
    output logic             logic_processor_halt_o,  // stop: program halted
    output logic             fieldbus_off_o,          // stop: fieldbus inactive
    output logic             hw_outputs_block_o,      // stop: outputs disabled
    output logic             image_freeze_o           // stop: image frozen
);

    localparam int IDW   = $clog2(NUM_ALARMS);   // alarm index width
    localparam int WORDS = NUM_ALARMS / 32;      // set-bit words

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (NUM_ALARMS % 32 != 0 || NUM_ALARMS > 128 || NUM_ALARMS < 32 ||
        DISP_SLOTS < 2 || DISP_SLOTS > 8) begin : g_bad
        $error("uam_alarm_manager: unsupported parameters");
    end

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [NUM_ALARMS-1:0] set_bits;                  // program-written
    logic [NUM_ALARMS-1:0] set_snap;                  // image for the walk
    logic [NUM_ALARMS-1:0] prev_set;                  // last walked level
    logic [NUM_ALARMS-1:0] active;                    // alarm pending
    logic [7:0]            cfg_mem   [NUM_ALARMS];    // user_alarm_config_table
    logic [31:0]           var_mem   [NUM_ALARMS];    // user_alarm_variables
    logic [IDW-1:0]        order_list[NUM_ALARMS];    // newest first
    logic [IDW:0]          count;                     // entries in list
    logic [UAM_RESP_W-1:0] status;                    // active responses
    logic                  key_pend;                  // key seen this cycle
    uam_state_t            state;                     // walk sequencer
    logic [IDW-1:0]        idx;                       // alarm being walked

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // position of an alarm in the list
    function automatic logic [IDW-1:0] find_pos(input logic [IDW-1:0] id);
        logic [IDW-1:0] pos;
        pos = '0;
        for (int j = 0; j < NUM_ALARMS; j++) begin
            if (IDW'(j) < count[IDW-1:0] + IDW'(0) || count[IDW]) begin
                if (order_list[j] == id && (IDW+1)'(j) < count)
                    pos = IDW'(j);
            end
        end
        return pos;
    endfunction

    // presented slot k: id in low bits, valid at bit 8
    function automatic logic [31:0] disp_entry(input int k);
        logic [31:0]  e;
        logic [IDW:0] src;
        e   = '0;
        src = (IDW+1)'(k);
        if (count > (IDW+1)'(DISP_SLOTS) && k != 0)
            src = count - (IDW+1)'(DISP_SLOTS) + (IDW+1)'(k);
        if (count > (IDW+1)'(DISP_SLOTS) || (IDW+1)'(k) < count) begin
            e[IDW-1:0]          = order_list[src[IDW-1:0]];
            e[UAM_DISP_VALID]   = 1'b1;
        end
        return e;
    endfunction

    // word index of a byte address in a region
    function automatic logic [IDW-1:0] word_idx(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] d;
        d = a - base;
        return d[IDW+1:2];
    endfunction

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic hit_set;   // set-bit words
    logic hit_cfg;   // config table
    logic hit_var;   // variable area
    logic hit_disp;  // presented slots

    always_comb begin
        hit_set  = addr_i >= UAM_SET_BASE && addr_i < UAM_SET_BASE + 12'(WORDS * 4);
        hit_cfg  = addr_i >= UAM_CFG_BASE && addr_i < UAM_CFG_BASE + 12'(NUM_ALARMS * 4);
        hit_var  = addr_i >= UAM_VAR_BASE && addr_i < UAM_VAR_BASE + 12'(NUM_ALARMS * 4);
        hit_disp = addr_i >= UAM_DISP_BASE && addr_i < UAM_DISP_BASE + 12'(DISP_SLOTS * 4);
    end

    // ----------------------------------------------------------------
    // walk decisions for the alarm under idx
    // ----------------------------------------------------------------
    logic      cur_set;    // snapped set bit
    logic      cur_prev;   // level at last walk
    logic      cur_act;    // pending now
    uam_crit_t cur_crit;   // clearing criterion
    logic      do_remove;  // clear this alarm
    logic      do_insert;  // raise this alarm
    logic      reraise;    // cleared but still set

    always_comb begin
        cur_set   = set_snap[idx];
        cur_prev  = prev_set[idx];
        cur_act   = active[idx];
        cur_crit  = uam_clear_crit(cfg_mem[idx]);
        do_remove = 1'b0;
        do_insert = 1'b0;
        if (state == UAM_SCAN) begin
            if (cur_act) begin
                case (cur_crit)
                    UAM_CLR_CAUSE: do_remove = !cur_set;
                    UAM_CLR_KEY:   do_remove = key_pend;
                    UAM_CLR_POWER: do_remove = 1'b0;
                    default:       do_remove = 1'b0;
                endcase
            end else begin
                do_insert = cur_set && !cur_prev;
            end
        end
        reraise = do_remove && cur_crit == UAM_CLR_KEY && cur_set;
    end

    // ----------------------------------------------------------------
    // walk sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= UAM_IDLE;
            idx   <= '0;
        end else begin
            case (state)
                UAM_IDLE: begin
                    if (cycle_tick_i && !status[UAM_BIT_STOP]) begin
                        state <= UAM_SCAN;
                        idx   <= '0;
                    end
                end
                UAM_SCAN: begin
                    if (reraise)
                        state <= UAM_REINS;
                    else if (idx == IDW'(NUM_ALARMS - 1))
                        state <= UAM_DONE;
                    else
                        idx <= idx + 1'b1;
                end
                UAM_REINS: begin
                    if (idx == IDW'(NUM_ALARMS - 1)) begin
                        state <= UAM_DONE;
                    end else begin
                        state <= UAM_SCAN;
                        idx   <= idx + 1'b1;
                    end
                end
                UAM_DONE: state <= UAM_IDLE;
                default:  state <= UAM_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // process image snapshot, frozen while stopped
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)
            set_snap <= '0;
        else if (state == UAM_IDLE && cycle_tick_i && !status[UAM_BIT_STOP])
            set_snap <= set_bits;
    end

    // ----------------------------------------------------------------
    // key request, held until the walk has used it
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)
            key_pend <= 1'b0;
        else if (key_clear_i)
            key_pend <= 1'b1;   // new press wins over clear
        else if (state == UAM_DONE)
            key_pend <= 1'b0;
    end

    // ----------------------------------------------------------------
    // active flags and edge history
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            active   <= '0;   // power cycle clears all
            prev_set <= '0;   // so still-set bits raise again
        end else if (state == UAM_SCAN) begin
            prev_set[idx] <= cur_set;
            if (do_remove)
                active[idx] <= 1'b0;
            else if (do_insert)
                active[idx] <= 1'b1;
        end else if (state == UAM_REINS) begin
            active[idx] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // ordered list, newest at head
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count <= '0;
            for (int j = 0; j < NUM_ALARMS; j++)
                order_list[j] <= '0;
        end else if (do_remove) begin
            for (int j = 0; j < NUM_ALARMS - 1; j++)
                if (IDW'(j) >= find_pos(idx))
                    order_list[j] <= order_list[j+1];
            count <= count - 1'b1;
        end else if (do_insert || state == UAM_REINS) begin
            for (int j = 1; j < NUM_ALARMS; j++)
                order_list[j] <= order_list[j-1];
            order_list[0] <= idx;
            count         <= count + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // responses of all active alarms
    // ----------------------------------------------------------------
    logic [UAM_RESP_W-1:0] next_status;   // or over active alarms

    always_comb begin
        next_status = '0;
        for (int i = 0; i < NUM_ALARMS; i++)
            if (active[i])
                next_status = next_status | cfg_mem[i][UAM_RESP_W-1:0];
    end

    // status and kernel signals settle after each walked program pass, held while stopped
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            status                <= '0;
            kern_start_inhibit_o  <= 1'b0;
            kern_readin_inhibit_o <= 1'b0;
            kern_feed_inhibit_o   <= 1'b0;
            kern_emergency_halt_o <= 1'b0;
        end else if (state == UAM_DONE) begin
            status                <= next_status;
            kern_start_inhibit_o  <= iface_start_inhibit_i  | next_status[UAM_BIT_START];
            kern_readin_inhibit_o <= iface_readin_inhibit_i | next_status[UAM_BIT_READIN];
            kern_feed_inhibit_o   <= iface_feed_inhibit_i   | next_status[UAM_BIT_FEED];
            kern_emergency_halt_o <= iface_emergency_halt_i | next_status[UAM_BIT_EHALT]
                                     | next_status[UAM_BIT_STOP];
        end
    end

    // stop consequences follow the stop status bit
    always_comb begin
        logic_processor_halt_o = status[UAM_BIT_STOP];
        fieldbus_off_o         = status[UAM_BIT_STOP];
        hw_outputs_block_o     = status[UAM_BIT_STOP];
        image_freeze_o         = status[UAM_BIT_STOP];
    end

    // ----------------------------------------------------------------
    // register writes: set bits, config, variables
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)
            set_bits <= '0;
        else if (wr_i && hit_set)   // byte n bit b is alarm 8n+b
            set_bits[32*word_idx(addr_i, UAM_SET_BASE) +: 32] <= wdata_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < NUM_ALARMS; i++)
                cfg_mem[i] <= UAM_CFG_RESET;
        end else if (wr_i && hit_cfg) begin
            cfg_mem[word_idx(addr_i, UAM_CFG_BASE)] <= wdata_i[7:0];
        end
    end

    // whole 32-bit words only, no partial lanes
    always_ff @(posedge clk_i) begin
        if (wr_i && hit_var)
            var_mem[word_idx(addr_i, UAM_VAR_BASE)] <= wdata_i;
    end

    // ----------------------------------------------------------------
    // register reads, data in the following cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= '0;   // unmapped reads as zero
            if (hit_set)
                rdata_o <= set_bits[32*word_idx(addr_i, UAM_SET_BASE) +: 32];
            else if (hit_cfg)
                rdata_o <= {24'h000000, cfg_mem[word_idx(addr_i, UAM_CFG_BASE)]};
            else if (hit_var)
                rdata_o <= var_mem[word_idx(addr_i, UAM_VAR_BASE)];
            else if (hit_disp)
                rdata_o <= disp_entry(int'(word_idx(addr_i, UAM_DISP_BASE)));
            else if (addr_i == UAM_STATUS_OFS)
                rdata_o <= {27'h0, status};
            else if (addr_i == UAM_COUNT_OFS)
                rdata_o <= 32'(count);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_walk_len;
        state == UAM_IDLE && cycle_tick_i && !status[UAM_BIT_STOP] |=> ##[31:300] state == UAM_DONE;
    endproperty
    a_walk_len: assert property (p_walk_len) else $error("walk did not finish in time");

    property p_head_new;
        do_insert |=> order_list[0] == $past(idx) && count == $past(count) + 1'b1;
    endproperty
    a_head_new: assert property (p_head_new) else $error("new alarm not at head");

    property p_disp_mix;
        count > (IDW+1)'(DISP_SLOTS) |-> disp_entry(0) == {23'h0, 1'b1, 8'(order_list[0])}
            && disp_entry(DISP_SLOTS-1) == {23'h0, 1'b1, 8'(order_list[count[IDW-1:0] - 1'b1])};
    endproperty
    a_disp_mix: assert property (p_disp_mix) else $error("presented slots wrong");

    property p_status;
        state == UAM_DONE |=> status == $past(next_status);
    endproperty
    a_status: assert property (p_status) else $error("status not updated");

    property p_cause_clear;
        state == UAM_SCAN && cur_act && cur_crit == UAM_CLR_CAUSE && !cur_set
            |=> count == $past(count) - 1'b1 && !active[$past(idx)];
    endproperty
    a_cause_clear: assert property (p_cause_clear) else $error("cause alarm not cleared");

    property p_key_clear;
        state == UAM_SCAN && cur_act && cur_crit == UAM_CLR_KEY && key_pend
            |=> !active[$past(idx)] && count == $past(count) - 1'b1;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("key alarm not cleared");

    property p_stop_power;
        do_remove |-> !cfg_mem[idx][UAM_BIT_STOP] && !cfg_mem[idx][UAM_BIT_POWER];
    endproperty
    a_stop_power: assert property (p_stop_power) else $error("power-cycle alarm removed");

    property p_reraise;
        reraise |=> state == UAM_REINS ##1 active[$past(idx, 2)] && order_list[0] == $past(idx, 2);
    endproperty
    a_reraise: assert property (p_reraise) else $error("still-set alarm not re-raised");

    property p_override;
        state == UAM_DONE && next_status[UAM_BIT_EHALT] |=> kern_emergency_halt_o [*2];
    endproperty
    a_override: assert property (p_override) else $error("emergency halt not forced");

    property p_stop_out;
        status[UAM_BIT_STOP] |-> logic_processor_halt_o && hw_outputs_block_o && fieldbus_off_o
            && image_freeze_o && kern_emergency_halt_o && state == UAM_IDLE && $stable(set_snap);
    endproperty
    a_stop_out: assert property (p_stop_out) else $error("stop consequences missing");

    c_insert:   cover property (do_insert);
    c_over8:    cover property (count > (IDW+1)'(DISP_SLOTS));
    c_reraise:  cover property (reraise);
    c_stopped:  cover property (status[UAM_BIT_STOP]);

endmodule // uam_alarm_manager

// ==== core/uam_pkg.sv ====
// constants and types shared by the user alarm manager
// assumes a single 100 MHz clock and word-wide register accesses
package uam_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int UAM_NUM_ALARMS = 128;   // user alarms
    localparam int UAM_DISP_SLOTS = 8;     // alarms presented
    localparam int UAM_ADDR_W     = 12;    // byte address width
    localparam int UAM_DATA_W     = 32;    // register word width
    localparam int UAM_RESP_W     = 5;     // response bits in status
    localparam int UAM_CFG_W      = 8;     // configuration byte width

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] UAM_SET_BASE   = 12'h000;  // set bits, 4 words
    localparam logic [11:0] UAM_STATUS_OFS = 12'h010;  // active responses
    localparam logic [11:0] UAM_COUNT_OFS  = 12'h014;  // active alarm count
    localparam logic [11:0] UAM_DISP_BASE  = 12'h020;  // presented slots
    localparam logic [11:0] UAM_CFG_BASE   = 12'h400;  // config table
    localparam logic [11:0] UAM_VAR_BASE   = 12'h800;  // alarm variables

    // ----------------------------------------------------------------
    // configuration byte / status fields
    // ----------------------------------------------------------------
    localparam int UAM_BIT_START  = 0;     // start inhibit
    localparam int UAM_BIT_READIN = 1;     // read-in inhibit
    localparam int UAM_BIT_FEED   = 2;     // feed inhibit all axes
    localparam int UAM_BIT_EHALT  = 3;     // emergency_halt
    localparam int UAM_BIT_STOP   = 4;     // logic_processor_halt
    localparam int UAM_BIT_KEY    = 6;     // key_clear
    localparam int UAM_BIT_POWER  = 7;     // power_cycle_clear
    localparam int UAM_DISP_VALID = 8;     // slot valid bit
    localparam logic [7:0] UAM_CFG_RESET = 8'h00;  // show only, cause-cleared

    // clearing criteria
    typedef enum logic [1:0] {
        UAM_CLR_CAUSE = 2'h0,
        UAM_CLR_KEY   = 2'h1,
        UAM_CLR_POWER = 2'h2
    } uam_crit_t;

    // walk sequencer states, gray along idle-scan-done
    typedef enum logic [1:0] {
        UAM_IDLE  = 2'h0,
        UAM_SCAN  = 2'h1,
        UAM_DONE  = 2'h3,
        UAM_REINS = 2'h2
    } uam_state_t;

    // clearing criterion from a configuration byte
    function automatic uam_crit_t uam_clear_crit(input logic [7:0] cfg);
        if (cfg[UAM_BIT_STOP] || cfg[UAM_BIT_POWER])
            return UAM_CLR_POWER;
        else if (cfg[UAM_BIT_KEY])
            return UAM_CLR_KEY;
        else
            return UAM_CLR_CAUSE;
    endfunction

endpackage

// ==== tb/test_user_alarm_manager.sv ====
// bench for the user alarm manager: register driver and scenarios
// assumes the program model supplies the pass ticks
`timescale 1ns/1ps
module test_user_alarm_manager;
    import uam_pkg::*;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, key = 0, tick;
    logic [11:0] addr = '0;
    logic [31:0] wd = '0, rdat;
    logic [3:0]  ifc = '0;  // start, readin, feed, halt from program
    logic        st, ri, fd, eh, hlt, fb, hw, fz;
    int          n_fail = 0, tests_run = 0;
    always #5 clk = ~clk;
    uam_program_model prog (.clk_i(clk), .sys_rst_i(rst), .cycle_tick_o(tick));
    uam_alarm_manager dut (.clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wd),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .cycle_tick_i(tick), .key_clear_i(key),
        .iface_start_inhibit_i(ifc[0]), .iface_readin_inhibit_i(ifc[1]),
        .iface_feed_inhibit_i(ifc[2]), .iface_emergency_halt_i(ifc[3]),
        .kern_start_inhibit_o(st), .kern_readin_inhibit_o(ri), .kern_feed_inhibit_o(fd),
        .kern_emergency_halt_o(eh), .logic_processor_halt_o(hlt), .fieldbus_off_o(fb),
        .hw_outputs_block_o(hw), .image_freeze_o(fz));
    // compare and count
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one-cycle write, then one-cycle read with data the cycle after
    task automatic wrw(logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic chkr(string nm, logic [11:0] a, logic [31:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        @(posedge clk);
        chk(nm, rdat, e);
    endtask
    // long enough for a tick plus a full walk
    task automatic walk();
        repeat (400) @(posedge clk);
    endtask
    // press well clear of a walk, so the next walk sees it from its start
    task automatic press();
        @(posedge clk iff tick);
        repeat (150) @(posedge clk);
        key <= 1;
        @(posedge clk);
        key <= 0;
    endtask
    task automatic t_list();
        for (int i = 0; i < 10; i++) begin
            wrw(UAM_SET_BASE, 32'((1 << (i + 1)) - 1));
            walk();
        end
        chkr("count", UAM_COUNT_OFS, 32'h0a);
        chkr("slot0", UAM_DISP_BASE, 32'h109);
        chkr("slot1", UAM_DISP_BASE + 12'h004, 32'h106);
        chkr("slot7", UAM_DISP_BASE + 12'h01c, 32'h100);
        chkr("status", UAM_STATUS_OFS, 32'h0);
        wrw(UAM_SET_BASE, 32'h0);
        walk();
        chkr("count", UAM_COUNT_OFS, 32'h0);
    endtask
    // start inhibit and emergency halt from the alarm, feed from the program
    task automatic t_cause();
        wrw(UAM_VAR_BASE + 12'h004, 32'ha5c30f96);
        chkr("var", UAM_VAR_BASE + 12'h004, 32'ha5c30f96);
        chkr("unmapped", 12'h300, 32'h0);
        wrw(UAM_CFG_BASE, 32'h09);
        wrw(UAM_SET_BASE, 32'h1);
        ifc <= 4'h4;
        walk();
        chkr("status", UAM_STATUS_OFS, 32'h09);
        chk("kern", {29'h0, eh, st, fd}, 32'h7);
        ifc <= 4'h0;
        wrw(UAM_SET_BASE, 32'h0);
        walk();
        chkr("status", UAM_STATUS_OFS, 32'h0);
        chk("kern", {29'h0, eh, st, fd}, 32'h0);
    endtask
    // alarm 1 key-cleared, alarm 2 cause-cleared, alarm 3 both clearing bits
    task automatic t_key();
        wrw(UAM_CFG_BASE + 12'h004, 32'h42);
        wrw(UAM_CFG_BASE + 12'h00c, 32'hc0);
        wrw(UAM_SET_BASE, 32'he);
        walk();
        chkr("slot0", UAM_DISP_BASE, 32'h103);
        press();
        walk();
        chkr("status", UAM_STATUS_OFS, 32'h02);
        chkr("slot0", UAM_DISP_BASE, 32'h101);
        chk("readin", {31'h0, ri}, 32'h1);
        wrw(UAM_SET_BASE, 32'h0);
        walk();
        chkr("status", UAM_STATUS_OFS, 32'h02);
        press();
        walk();
        chkr("status", UAM_STATUS_OFS, 32'h0);
        chkr("count", UAM_COUNT_OFS, 32'h1);
    endtask
    task automatic t_stop();
        wrw(UAM_CFG_BASE + 12'h008, 32'h50);
        wrw(UAM_SET_BASE, 32'h4);
        walk();
        chkr("status", UAM_STATUS_OFS, 32'h10);
        chk("halt", {27'h0, hlt, fb, hw, fz, eh}, 32'h1f);
        wrw(UAM_SET_BASE, 32'h0);
        press();
        walk();
        chkr("status", UAM_STATUS_OFS, 32'h10);
        rst <= 1;
        repeat (6) @(posedge clk);
        rst <= 0;
        chkr("status", UAM_STATUS_OFS, 32'h0);
        chkr("count", UAM_COUNT_OFS, 32'h0);
        chk("halt", {27'h0, hlt, fb, hw, fz, eh}, 32'h0);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        t_list();
        t_cause();
        t_key();
        t_stop();
        end_sim();
    end
    // watchdog well beyond the expected run
    initial begin
        #300000;
        n_fail++;
        end_sim();
    end
endmodule // test_user_alarm_manager

// ==== tb/uam_program_model.sv ====
// user program model: one end-of-pass tick every PERIOD clocks
// assumes synchronous active-high reset on the shared clock
`timescale 1ns/1ps
module uam_program_model #(
    parameter int PERIOD = 200  // clocks per program pass
) (
    input  wire logic clk_i,        // system clock
    input  wire logic sys_rst_i,    // power cycle
    output logic      cycle_tick_o  // pass finished
);
    int cnt;  // clocks into the pass
    // free-running pass counter, tick registered from its last clock, so high on the first clock of the next pass
    always_ff @(posedge clk_i) begin
        cnt <= (sys_rst_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
        cycle_tick_o <= !sys_rst_i && cnt == PERIOD - 1;
    end
endmodule // uam_program_model
